// File: inc/sbc_map.vh
`ifndef SBC_MAP_VH
`define SBC_MAP_VH

// register byte addresses on the plain register port
`define SBC_ADDR_W 16
`define SBC_ADDR_CTRL 16'h1103
`define SBC_ADDR_IRQ_MASK 16'h1107
`define SBC_ADDR_IRQ_STAT 16'h110b
`define SBC_ADDR_CNT_B3 16'h1110
`define SBC_ADDR_CNT_B2 16'h1111
`define SBC_ADDR_CNT_B1 16'h1112
`define SBC_ADDR_CNT_B0 16'h1113

// field positions
`define SBC_CTRL_MODE_BIT 0
`define SBC_IRQ_PAR_BIT 3

// reset values and writable bits
`define SBC_CTRL_RST 8'h00
`define SBC_CTRL_WR_MASK 8'h7f
`define SBC_MASK_RST 8'h08
`define SBC_MASK_WR_MASK 8'h08
`define SBC_STAT_RST 8'h00
`define SBC_CNT_RST 32'h0000_0000
`define SBC_CNT_MAX 32'hffff_ffff

// parity width and worst case bit errors per frame
`define SBC_PAR_W 8
`define SBC_MAX_BIT_ERR 4'h8

`endif

// File: verilog/sbc_bip8_acc.v
`timescale 1ns/1ps
`default_nettype none

// running bit-interleaved parity over one frame, held at the next frame start
module sbc_bip8_acc #(
   parameter W = 8
) (
   input wire clk,
   input wire sys_rst,
   input wire byte_valid,
   input wire frame_start,
   input wire [W-1:0] byte_data,
   output reg [W-1:0] held_par_r,
   output reg held_ok_r
);

   reg [W-1:0] acc_r; // parity of the frame in progress
   reg [W-1:0] acc_nxt;
   reg in_frame_r; // a frame start has been seen
   reg [W-1:0] held_nxt;
   reg held_ok_nxt;
   reg in_frame_nxt;

   // even parity per bit position: xor of all bytes of the frame
   always @*
   begin
      acc_nxt = acc_r;
      held_nxt = held_par_r;
      held_ok_nxt = held_ok_r;
      in_frame_nxt = in_frame_r;
      if (byte_valid && frame_start)
      begin
         // only a frame seen from its first byte gives a full reference
         held_nxt = acc_r;
         held_ok_nxt = in_frame_r;
         acc_nxt = byte_data;
         in_frame_nxt = 1'b1;
      end
      else if (byte_valid)
      begin
         acc_nxt = acc_r ^ byte_data;
      end
   end

   // state update
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         acc_r <= {W{1'b0}};
         held_par_r <= {W{1'b0}};
         held_ok_r <= 1'b0;
         in_frame_r <= 1'b0;
      end
      else
      begin
         acc_r <= acc_nxt;
         held_par_r <= held_nxt;
         held_ok_r <= held_ok_nxt;
         in_frame_r <= in_frame_nxt;
      end
   end

endmodule // sbc_bip8_acc

`default_nettype wire

// File: verilog/sbc_checker.v
// Operation
// RULE1: even bip-8 over every byte of frame
// RULE2: compare held parity with next frame's parity byte
// RULE3: parity error sets status bit 3, interrupt low
// RULE4: 32-bit error counter over four byte addresses
// RULE5: mode bit 0 one: add one per errored frame
// RULE6: mode bit 0 zero: add mismatched bit count
// RULE7: status clears on read; counter read-only
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "sbc_map.vh"

module sbc_checker (
   input wire clk,
   input wire sys_rst,
   // receive frame stream, same clock domain as the framer
   input wire rx_valid,
   input wire rx_frame_start,
   input wire rx_par_byte,
   input wire [7:0] rx_data,
   // register port
   input wire [`SBC_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata_r,
   // interrupt, active low level
   output reg irq_n_r,
   // live flag: a parity error was seen, one cycle
   output reg par_err_r
);

   // checker states
   localparam [1:0] ST_IDLE = 2'b00; // no frame seen yet
   localparam [1:0] ST_FIRST = 2'b01; // first frame, no reference yet
   localparam [1:0] ST_CHECK = 2'b10; // reference held, checking

   reg [1:0] state_r;
   reg [1:0] state_nxt;

   // parity accumulator outputs
   wire [`SBC_PAR_W-1:0] held_par;
   wire held_ok;

   // registers seen by software
   reg [7:0] ctrl_r; // control byte 0
   reg [7:0] ctrl_nxt;
   reg [7:0] mask_r; // interrupt enables
   reg [7:0] mask_nxt;
   reg [7:0] stat_r; // sticky interrupt status
   reg [7:0] stat_nxt;
   reg [31:0] cnt_r; // parity error counter
   reg [31:0] cnt_nxt;

   // compare pipeline
   reg [`SBC_PAR_W-1:0] diff_r; // mismatched bit positions
   reg [`SBC_PAR_W-1:0] diff_nxt;
   reg diff_vld_r; // one cycle after a compared parity byte
   reg diff_vld_nxt;
   reg checked_r; // parity byte already used in this frame
   reg checked_nxt;

   // event and read helpers
   reg [3:0] bit_err; // ones in diff_r
   reg [31:0] inc; // amount to add this cycle
   reg err_ev; // errored frame this cycle
   reg [7:0] rd_mux; // read data before the output flop
   reg stat_rd; // status byte being read
   reg irq_nxt;
   integer i;

   wire mode_per_frame;
   assign mode_per_frame = ctrl_r[`SBC_CTRL_MODE_BIT];

   // running parity, held at each frame start
   sbc_bip8_acc #(
      .W(`SBC_PAR_W)
   ) u_acc (
      .clk(clk),
      .sys_rst(sys_rst),
      .byte_valid(rx_valid),
      .frame_start(rx_frame_start),
      .byte_data(rx_data),
      .held_par_r(held_par), // [RULE1]
      .held_ok_r(held_ok)
   );

   // state sequencing follows frame starts
   always @*
   begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE:
         begin
            // wait for the first frame boundary
            if (rx_valid && rx_frame_start)
            begin
               state_nxt = ST_FIRST;
            end
         end
         ST_FIRST:
         begin
            // second boundary closes a whole reference frame
            if (rx_valid && rx_frame_start)
            begin
               state_nxt = ST_CHECK;
            end
         end
         ST_CHECK:
         begin
            state_nxt = ST_CHECK;
         end
         default:
         begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   // compare the parity byte of this frame with the held parity
   always @*
   begin
      diff_nxt = diff_r;
      diff_vld_nxt = 1'b0;
      checked_nxt = checked_r;
      if (rx_valid && rx_frame_start)
      begin
         // a new frame allows one new compare
         checked_nxt = 1'b0;
      end
      // the parity byte never coincides with the frame's first byte
      if (rx_valid && rx_par_byte && !rx_frame_start && !checked_r &&
          state_r == ST_CHECK && held_ok)
      begin
         diff_nxt = held_par ^ rx_data; // [RULE2]
         diff_vld_nxt = 1'b1;
         checked_nxt = 1'b1;
      end
   end

   // count mismatched bits
   always @*
   begin
      bit_err = 4'h0;
      for (i = 0; i < `SBC_PAR_W; i = i + 1)
      begin
         bit_err = bit_err + {3'b000, diff_r[i]};
      end
   end

   // errored frame and counter increment
   always @*
   begin
      err_ev = diff_vld_r && (diff_r != {`SBC_PAR_W{1'b0}}); // [RULE2]
      inc = 32'h0000_0000;
      if (err_ev)
      begin
         if (mode_per_frame)
         begin
            inc = 32'h0000_0001; // [RULE5]
         end
         else
         begin
            inc = {28'h000_0000, bit_err}; // [RULE6]
         end
      end
   end

   // counter: saturates so a long error burst never wraps to small
   always @*
   begin
      if (cnt_r > `SBC_CNT_MAX - inc)
      begin
         cnt_nxt = `SBC_CNT_MAX;
      end
      else
      begin
         cnt_nxt = cnt_r + inc; // [RULE4]
      end
   end

   // register writes; counter and status have no write path
   always @*
   begin
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      if (reg_wr)
      begin
         case (reg_addr)
            `SBC_ADDR_CTRL:
            begin
               ctrl_nxt = reg_wdata & `SBC_CTRL_WR_MASK;
            end
            `SBC_ADDR_IRQ_MASK:
            begin
               mask_nxt = reg_wdata & `SBC_MASK_WR_MASK;
            end
            default:
            begin
               // counter bytes and unmapped addresses ignore writes [RULE7]
               ctrl_nxt = ctrl_r;
            end
         endcase
      end
   end

   // sticky status: a new error beats the clear-on-read
   always @*
   begin
      stat_rd = reg_rd && (reg_addr == `SBC_ADDR_IRQ_STAT);
      stat_nxt = stat_r;
      if (stat_rd)
      begin
         stat_nxt = `SBC_STAT_RST; // [RULE7]
      end
      if (err_ev)
      begin
         stat_nxt[`SBC_IRQ_PAR_BIT] = 1'b1; // [RULE3]
      end
   end

   // interrupt pin low while an enabled status bit is set
   always @*
   begin
      irq_nxt = ~|(stat_nxt & mask_r); // [RULE3]
   end

   // read data mux; unmapped addresses read zero
   always @*
   begin
      rd_mux = 8'h00;
      case (reg_addr)
         `SBC_ADDR_CTRL:
         begin
            rd_mux = ctrl_r;
         end
         `SBC_ADDR_IRQ_MASK:
         begin
            rd_mux = mask_r;
         end
         `SBC_ADDR_IRQ_STAT:
         begin
            rd_mux = stat_r;
         end
         `SBC_ADDR_CNT_B3:
         begin
            rd_mux = cnt_r[31:24]; // [RULE4]
         end
         `SBC_ADDR_CNT_B2:
         begin
            rd_mux = cnt_r[23:16];
         end
         `SBC_ADDR_CNT_B1:
         begin
            rd_mux = cnt_r[15:8];
         end
         `SBC_ADDR_CNT_B0:
         begin
            rd_mux = cnt_r[7:0];
         end
         default:
         begin
            rd_mux = 8'h00;
         end
      endcase
   end

   // all state flops
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         state_r <= ST_IDLE;
         ctrl_r <= `SBC_CTRL_RST;
         mask_r <= `SBC_MASK_RST;
         stat_r <= `SBC_STAT_RST;
         cnt_r <= `SBC_CNT_RST;
         diff_r <= {`SBC_PAR_W{1'b0}};
         diff_vld_r <= 1'b0;
         checked_r <= 1'b0;
         reg_rdata_r <= 8'h00;
         irq_n_r <= 1'b1;
         par_err_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         ctrl_r <= ctrl_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         cnt_r <= cnt_nxt;
         diff_r <= diff_nxt;
         diff_vld_r <= diff_vld_nxt;
         checked_r <= checked_nxt;
         // read data stand for one cycle only
         reg_rdata_r <= reg_rd ? rd_mux : 8'h00;
         irq_n_r <= irq_nxt;
         par_err_r <= err_ev;
      end
   end

endmodule // sbc_checker

`default_nettype wire

// File: test/sbc_chk_asrt_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbc_map.vh"

// port-level checks on the parity checker
module sbc_chk_asrt (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic rx_valid,
   input wire logic rx_frame_start,
   input wire logic rx_par_byte,
   input wire logic [7:0] rx_data,
   input wire logic [`SBC_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata_r,
   input wire logic irq_n_r,
   input wire logic par_err_r
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic msk_r; // shadow of the mask enable bit
   logic rst_seen_r = 1'b0; // a reset edge has passed, outputs are defined
   wire logic st_rd = reg_rd && reg_addr == `SBC_ADDR_IRQ_STAT;
   wire logic ct_rd = reg_rd && reg_addr == `SBC_ADDR_CTRL;
   // track mask writes so the irq check knows if it may fire
   always @(posedge clk)
   begin
      if (sys_rst)
      begin
         msk_r <= 1'b1;
         rst_seen_r <= 1'b1;
      end
      else if (reg_wr && reg_addr == `SBC_ADDR_IRQ_MASK)
         msk_r <= reg_wdata[`SBC_IRQ_PAR_BIT];
   end
   // status read with no new error in the same cycle
   sequence stat_rd_s;
      st_rd ##1 !par_err_r;
   endsequence
   rst_idle_a: assert property (disable iff (1'b0)
      rst_seen_r && $past(sys_rst) |-> irq_n_r && !par_err_r && reg_rdata_r == 8'h00)
      else $error("outputs not idle after reset");
   rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata_r == 8'h00)
      else $error("read data outside read slot");
   err_src_a: assert property (par_err_r |-> $past(rx_valid && rx_par_byte, 2))
      else $error("error pulse without parity byte");
   err_irq_a: assert property (par_err_r && msk_r |-> !irq_n_r)
      else $error("error did not pull interrupt low");
   irq_src_a: assert property ($fell(irq_n_r) |-> par_err_r || $past(reg_wr, 2))
      else $error("interrupt fell without cause");
   stat_hold_a: assert property (st_rd && !irq_n_r |=> reg_rdata_r[3])
      else $error("pending status bit read as zero");
   rd_clear_a: assert property (stat_rd_s |-> irq_n_r)
      else $error("status read did not clear interrupt");
   stat_rsv_a: assert property (st_rd |=> (reg_rdata_r & 8'hf7) == 8'h00)
      else $error("unused status bits set");
   ctrl_top_a: assert property (ct_rd |=> !reg_rdata_r[7])
      else $error("control bit 7 read as one");
endmodule // sbc_chk_asrt

bind sbc_checker sbc_chk_asrt sbc_chk_asrt_inst (
   .clk(clk), .sys_rst(sys_rst), .rx_valid(rx_valid),
   .rx_frame_start(rx_frame_start), .rx_par_byte(rx_par_byte),
   .rx_data(rx_data), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_r(reg_rdata_r),
   .irq_n_r(irq_n_r), .par_err_r(par_err_r));
`default_nettype wire

// File: test/sbc_line_src.sv
`timescale 1ns/1ps
`default_nettype none

// line side: sends frames with a true or spoiled parity byte
module sbc_line_src (
   input wire logic clk,
   output logic rx_valid,
   output logic rx_frame_start,
   output logic rx_par_byte,
   output logic [7:0] rx_data
);
   logic [7:0] acc_r = 8'h00; // parity of bytes sent so far
   logic [7:0] ref_r = 8'h00; // parity of the last whole frame
   initial
   begin
      rx_valid = 1'b0;
      rx_frame_start = 1'b0;
      rx_par_byte = 1'b0;
      rx_data = 8'h00;
   end
   // n bytes, parity byte second, flip spoils chosen bits
   task automatic frame(input int n, input logic [7:0] flip);
      logic [7:0] d;
      for (int i = 0; i < n; i++)
      begin
         @(posedge clk);
         if (i == 0)
         begin
            ref_r = acc_r;
            acc_r = 8'h00;
         end
         d = (i == 1) ? ref_r ^ flip : 8'(i * 37 + n);
         acc_r = acc_r ^ d;
         rx_valid <= 1'b1;
         rx_frame_start <= i == 0;
         rx_par_byte <= i == 1;
         rx_data <= d;
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      rx_frame_start <= 1'b0;
      rx_par_byte <= 1'b0;
      rx_data <= ~d; // idle line must not look like the last byte
   endtask
endmodule // sbc_line_src
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "sbc_map.vh"

module testbench;
   logic clk, sys_rst, reg_wr, reg_rd;
   logic [`SBC_ADDR_W-1:0] reg_addr;
   logic [7:0] reg_wdata, rd_v;
   wire logic rx_valid, rx_frame_start, rx_par_byte, irq_n_r, par_err_r;
   wire logic [7:0] rx_data, reg_rdata_r;
   int failures = 0;
   int compares = 0;
   int err_seen = 0; // error pulses seen on the pin
   logic [31:0] cnt_e = 32'h0; // expected error count
   sbc_checker sbc_checker_inst (.clk(clk), .sys_rst(sys_rst),
      .rx_valid(rx_valid), .rx_frame_start(rx_frame_start),
      .rx_par_byte(rx_par_byte), .rx_data(rx_data), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata_r(reg_rdata_r), .irq_n_r(irq_n_r), .par_err_r(par_err_r));
   sbc_line_src src (.clk(clk), .rx_valid(rx_valid),
      .rx_frame_start(rx_frame_start), .rx_par_byte(rx_par_byte),
      .rx_data(rx_data));
   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // count one-cycle error pulses
   always @(posedge clk)
   begin
      if (par_err_r)
         err_seen++;
   end
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // data is sampled in the single cycle it stands
   task rdc(input logic [15:0] a, input logic [7:0] e);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rd_v = reg_rdata_r;
      chk("reg", {24'h0, e}, {24'h0, rd_v});
   endtask
   // counter read high byte first; live, so only read when quiet
   task automatic cnt_chk;
      for (int i = 0; i < 4; i++)
      begin
         rdc(16'(`SBC_ADDR_CNT_B3 + i), cnt_e[31-8*i -: 8]);
      end
   endtask
   // spoiled frame, then status, interrupt and count
   task err(input logic [7:0] flip, input logic [31:0] inc);
      src.frame(12, flip);
      cnt_e = cnt_e + inc;
      chk("irq", 0, irq_n_r);
      rdc(`SBC_ADDR_IRQ_STAT, 8'h08);
      rdc(`SBC_ADDR_IRQ_STAT, 8'h00);
      chk("irq", 1, irq_n_r);
      cnt_chk;
   endtask
   task stop_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // hang guard
   initial
   begin
      repeat (20000) @(posedge clk);
      failures++;
      stop_test;
   end
   initial
   begin
      sys_rst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 8'h00;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      rdc(`SBC_ADDR_CTRL, 8'h00);
      rdc(`SBC_ADDR_IRQ_MASK, 8'h08);
      rdc(`SBC_ADDR_IRQ_STAT, 8'h00);
      rdc(16'h1100, 8'h00);
      wr(`SBC_ADDR_CTRL, 8'hff);
      rdc(`SBC_ADDR_CTRL, 8'h7f);
      wr(`SBC_ADDR_CNT_B0, 8'h55);
      cnt_chk;
      wr(`SBC_ADDR_CTRL, 8'h01);
      // first frame has no reference yet, so its bad byte is ignored
      src.frame(12, 8'hff);
      src.frame(12, 8'h00);
      src.frame(12, 8'h00);
      chk("irq", 1, irq_n_r);
      cnt_chk;
      err(8'h0f, 1);
      wr(`SBC_ADDR_CTRL, 8'h00);
      err(8'hff, 8);
      err(8'h24, 2);
      // masked: status still set, pin stays quiet
      wr(`SBC_ADDR_IRQ_MASK, 8'h00);
      src.frame(12, 8'h10);
      cnt_e = cnt_e + 1;
      chk("irq", 1, irq_n_r);
      // unmasking a pending status pulls the pin low
      wr(`SBC_ADDR_IRQ_MASK, 8'h08);
      repeat (2) @(posedge clk);
      chk("irq", 0, irq_n_r);
      rdc(`SBC_ADDR_IRQ_STAT, 8'h08);
      chk("irq", 1, irq_n_r);
      cnt_chk;
      chk("par_err", 4, err_seen);
      stop_test;
   end
endmodule // testbench
`default_nettype wire
